/* File: hw/cct_core_timing.sv */
`timescale 1ns/1ps
// Operation
// RQ1: External data moves always target program flash
// RQ2: Add, addc, subb timing by operand mode
// RQ3: AND into accumulator timing by operand mode
// RQ4: Code byte move: 1 byte, 3 cycles
// RQ5: External data moves: 1 byte, 3 cycles
// RQ6: Push and pop: 2 bytes, 2 cycles
// RQ7: Exchange forms timing by operand mode
// RQ8: Carry ops 1/1; bit ops 2/2
// RQ9: Carry jumps: 2 bytes, 2 or 3
// RQ10: Bit jumps 3 bytes; clear-variant clears bit
// RQ11: Calls, jumps, returns fixed lengths and cycles
// RQ12: Indirect jump: 1 byte, 3 cycles
// RQ13: Accumulator-zero jump: 2 bytes, 2 or 3
// RQ14: Illegal flash or fetch address resets
// RQ15: Write or erase above limit resets
// RQ16: Code byte read above limit resets
// RQ17: Branch above limit resets
// RQ18: Limit per variant: 1DFF, 0FFF, 07FF
// RQ19: Flash fault sets source bit six
// RQ20: Internal resets leave reset pin alone
// RQ21: Writing bit four forces reset, reads one
// RQ22: Fetch at 0000 after 5 us wait
// RQ23: Not taken uses smaller, taken larger
module cct_core_timing
    import cct_pkg::*;
#(
    parameter int VARIANT = 0
)
(
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_pin_rst,
    input wire logic i_op_valid,
    input wire logic [7:0] i_opcode,
    input wire logic i_cond_taken,
    input wire logic i_bit_value,
    input wire logic [15:0] i_pc,
    input wire logic [15:0] i_target,
    input wire logic i_is_branch,
    input wire logic [15:0] i_mem_addr,
    input wire logic i_program_store_write_enable,
    input wire logic i_rsrc_wr,
    input wire logic [7:0] i_rsrc_wdata,
    output logic o_op_ready,
    output logic o_done,
    output logic [1:0] o_len,
    output logic [3:0] o_cycles,
    output logic o_clear_bit,
    output logic o_flash_sel,
    output logic o_flash_wr,
    output logic o_flash_rd,
    output logic [15:0] o_fetch_addr,
    output logic o_core_rst,
    output logic o_pin_rst_drive,
    output logic [7:0] o_reset_source_register
);

    // Variant limit chosen at build time
    localparam logic [15:0] LIMIT = (VARIANT == 2) ? CCT_LIMIT_SMALL :
        (VARIANT == 1) ? CCT_LIMIT_MID : CCT_LIMIT_LARGE; // RQ18

    // Pin reset comes from outside the clock domain
    logic pin_s1_q;
    logic pin_s2_q;

    // Decoded timing of the current opcode
    logic [1:0] len_d;
    logic [3:0] cyc_d;
    logic is_xmove_d;
    logic is_xmove_wr_d;
    logic is_cmove_d;
    logic is_bitclr_d;
    logic fault_d;
    logic sw_force_d;

    cct_state_t state_q;
    logic [3:0] cnt_q;
    logic [9:0] start_q;
    logic [3:0] cyc_q;
    logic [1:0] len_q;
    logic done_q;
    logic clr_q;
    logic flash_sel_q;
    logic flash_wr_q;
    logic flash_rd_q;
    logic [15:0] fetch_q;
    logic int_rst_q;
    logic ferr_q;
    logic swf_q;

    // Conditional branches pick one of two counts
    function automatic logic [3:0] cond_cyc(input logic [3:0] base,
                                            input logic taken);
        cond_cyc = taken ? base + CCT_CYC_1 : base; // RQ23
    endfunction

    // Two-flop synchroniser for the pin reset
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end
        else
        begin
            pin_s1_q <= i_pin_rst;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Opcode decode into length and cycle count
    always_comb
    begin
        len_d = CCT_LEN_1;
        cyc_d = CCT_CYC_1;
        is_xmove_d = 1'b0;
        is_xmove_wr_d = 1'b0;
        is_cmove_d = 1'b0;
        is_bitclr_d = 1'b0;
        // Register forms of add, addc, subb, anl, xch
        if ((i_opcode[7:4] == 4'h2 || i_opcode[7:4] == 4'h3 ||
             i_opcode[7:4] == 4'h9 || i_opcode[7:4] == 4'h5 ||
             i_opcode[7:4] == 4'hC) && i_opcode[3])
        begin
            len_d = CCT_LEN_1; // RQ2 RQ3 RQ7
            cyc_d = CCT_CYC_1;
        end
        // Immediate, direct and indirect forms of add, addc, subb and anl
        else if ((i_opcode[7:4] == 4'h2 || i_opcode[7:4] == 4'h3 ||
                  i_opcode[7:4] == 4'h9 || i_opcode[7:4] == 4'h5) &&
                 i_opcode[3:2] == 2'h1)
        begin
            len_d = (i_opcode[1]) ? CCT_LEN_1 : CCT_LEN_2; // RQ2 RQ3
            cyc_d = CCT_CYC_2;
        end
        else
        begin
            case (i_opcode)
                8'h83: begin is_cmove_d = 1'b1; cyc_d = CCT_CYC_3; end // RQ4
                8'hE2, 8'hE3, 8'hE0, 8'hF2, 8'hF3, 8'hF0:
                begin
                    // Upper nibble F marks the write forms
                    is_xmove_d = 1'b1; // RQ5
                    is_xmove_wr_d = i_opcode[4];
                    cyc_d = CCT_CYC_3;
                end
                8'hC6, 8'hC7, 8'hD6, 8'hD7: cyc_d = CCT_CYC_2; // RQ7
                8'hC3, 8'hD3, 8'hB3: cyc_d = CCT_CYC_1; // RQ8
                8'hC0, 8'hD0, 8'hC5, 8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0,
                8'h72, 8'hA0, 8'hA2, 8'h92:
                begin
                    len_d = CCT_LEN_2; // RQ6 RQ7 RQ8
                    cyc_d = CCT_CYC_2;
                end
                8'h40, 8'h50, 8'h60:
                begin
                    len_d = CCT_LEN_2; // RQ9 RQ13
                    cyc_d = cond_cyc(CCT_CYC_2, i_cond_taken);
                end
                8'h20, 8'h30, 8'h10:
                begin
                    len_d = CCT_LEN_3; // RQ10
                    cyc_d = cond_cyc(CCT_CYC_3, i_cond_taken);
                    is_bitclr_d = (i_opcode == 8'h10);
                end
                8'h12, 8'h02:
                begin
                    len_d = CCT_LEN_3; // RQ11
                    cyc_d = CCT_CYC_4;
                end
                8'h80:
                begin
                    len_d = CCT_LEN_2; // RQ11
                    cyc_d = CCT_CYC_3;
                end
                8'h22, 8'h32: cyc_d = CCT_CYC_5; // RQ11
                8'h73: cyc_d = CCT_CYC_3; // RQ12
                default:
                begin
                    // Absolute call and jump share low four bits
                    if (i_opcode[3:0] == 4'h1)
                    begin
                        len_d = CCT_LEN_2; // RQ11
                        cyc_d = CCT_CYC_3;
                    end
                end
            endcase
        end
    end

    // Fault when a flash write, code byte read, taken branch target or fetch goes past the limit
    always_comb
    begin
        fault_d = 1'b0;
        if (i_op_valid && o_op_ready)
        begin
            if (is_xmove_wr_d && i_program_store_write_enable &&
                i_mem_addr > LIMIT)
                fault_d = 1'b1; // RQ14 RQ15
            if (is_cmove_d && i_mem_addr > LIMIT)
                fault_d = 1'b1; // RQ16
            if (i_is_branch && i_cond_taken && i_target > LIMIT)
                fault_d = 1'b1; // RQ17
            if (i_pc > LIMIT)
                fault_d = 1'b1; // RQ14
        end
    end

    // Software force, bit four of the source register
    assign sw_force_d = i_rsrc_wr && i_rsrc_wdata[CCT_SW_FORCE_BIT]; // RQ21

    // Internal reset pulse; pin drive never asserted
    always_ff @(posedge i_ref_clk)
    begin
        int_rst_q <= !i_sys_rst && (fault_d || sw_force_d);
    end
    assign o_pin_rst_drive = 1'b0; // RQ20

    // Reset cause flags survive the internal reset they trigger
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst || pin_s2_q)
        begin
            // A pin reset clears both cause flags
            ferr_q <= 1'b0;
            swf_q <= 1'b0;
        end
        else if (fault_d || sw_force_d)
        begin
            ferr_q <= fault_d; // RQ19
            swf_q <= sw_force_d; // RQ21
        end
    end

    // Main timing sequencer
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst || pin_s2_q || int_rst_q)
        begin
            state_q <= CCT_ST_HOLD;
            start_q <= CCT_START_CNT; // RQ22
            cnt_q <= 4'h0;
            cyc_q <= 4'h0;
            len_q <= 2'h0;
            done_q <= 1'b0;
            clr_q <= 1'b0;
            flash_sel_q <= 1'b0;
            flash_wr_q <= 1'b0;
            flash_rd_q <= 1'b0;
            fetch_q <= CCT_RESET_VECTOR; // RQ22
        end
        else
        begin
            done_q <= 1'b0;
            case (state_q)
                CCT_ST_HOLD:
                begin
                    // Hold fetch off for the start delay
                    if (start_q == 10'h001)
                        state_q <= CCT_ST_IDLE; // RQ22
                    start_q <= start_q - 10'h001;
                end
                CCT_ST_IDLE:
                begin
                    if (i_op_valid && !fault_d)
                    begin
                        cyc_q <= cyc_d;
                        len_q <= len_d;
                        cnt_q <= cyc_d;
                        clr_q <= is_bitclr_d && i_bit_value; // RQ10
                        flash_sel_q <= is_xmove_d; // RQ1
                        flash_wr_q <= is_xmove_wr_d &&
                            i_program_store_write_enable; // RQ1
                        flash_rd_q <= (is_xmove_d && !is_xmove_wr_d) ||
                            is_cmove_d;
                        fetch_q <= i_pc;
                        state_q <= CCT_ST_BUSY;
                    end
                end
                CCT_ST_BUSY:
                begin
                    // Count down the instruction's cycles
                    if (cnt_q == 4'h1)
                    begin
                        done_q <= 1'b1;
                        state_q <= CCT_ST_IDLE;
                        flash_sel_q <= 1'b0;
                        flash_wr_q <= 1'b0;
                        flash_rd_q <= 1'b0;
                    end
                    cnt_q <= cnt_q - 4'h1;
                end
                default: state_q <= CCT_ST_HOLD;
            endcase
        end
    end

    assign o_op_ready = (state_q == CCT_ST_IDLE);
    assign o_done = done_q;
    assign o_len = len_q;
    assign o_cycles = cyc_q;
    assign o_clear_bit = clr_q;
    assign o_flash_sel = flash_sel_q;
    assign o_flash_wr = flash_wr_q;
    assign o_flash_rd = flash_rd_q;
    assign o_fetch_addr = fetch_q;
    assign o_core_rst = int_rst_q || (state_q == CCT_ST_HOLD);
    assign o_reset_source_register = {1'b0, ferr_q, 1'b0, swf_q, 4'h0};

    // Assertions
    property p_fault_rst;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        fault_d |=> int_rst_q ##1 (state_q == CCT_ST_HOLD);
    endproperty
    a_fault_rst: assert property (p_fault_rst) // RQ15
        else $error("fault did not reset");
    property p_ferr;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (fault_d && !pin_s2_q) |=> o_reset_source_register[6];
    endproperty
    a_ferr: assert property (p_ferr) // RQ19
        else $error("flash fault flag not set");
    property p_swf;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (sw_force_d && !pin_s2_q) |=> int_rst_q && swf_q;
    endproperty
    a_swf: assert property (p_swf) // RQ21
        else $error("software reset failed");
    property p_pin;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        int_rst_q |-> !o_pin_rst_drive;
    endproperty
    a_pin: assert property (p_pin) // RQ20
        else $error("reset pin driven");
    property p_vec;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        $rose(int_rst_q) |=> (o_fetch_addr == 16'h0000) && o_core_rst;
    endproperty
    a_vec: assert property (p_vec) // RQ22
        else $error("fetch not at reset vector");
    property p_xmove;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (o_op_ready && i_op_valid && !fault_d && i_opcode == 8'hE0)
            |=> o_flash_sel && o_cycles == 4'h3 ##3 o_done;
    endproperty
    a_xmove: assert property (p_xmove) // RQ5
        else $error("external move timing wrong");
    property p_jc;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (o_op_ready && i_op_valid && !fault_d && i_opcode == 8'h40)
            |=> o_len == 2'h2 &&
            o_cycles == ($past(i_cond_taken) ? 4'h3 : 4'h2);
    endproperty
    a_jc: assert property (p_jc) // RQ9
        else $error("carry jump timing wrong");
    property p_ret;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (o_op_ready && i_op_valid && !fault_d && i_opcode == 8'h22)
            |=> !o_done [*5] ##1 o_done;
    endproperty
    a_ret: assert property (p_ret) // RQ11
        else $error("return not five cycles");

endmodule

/* File: hw/cct_pkg.sv */
package cct_pkg;
    // Byte lengths and cycle counts
    localparam logic [1:0] CCT_LEN_1 = 2'h1;
    localparam logic [1:0] CCT_LEN_2 = 2'h2;
    localparam logic [1:0] CCT_LEN_3 = 2'h3;
    localparam logic [3:0] CCT_CYC_1 = 4'h1;
    localparam logic [3:0] CCT_CYC_2 = 4'h2;
    localparam logic [3:0] CCT_CYC_3 = 4'h3;
    localparam logic [3:0] CCT_CYC_4 = 4'h4;
    localparam logic [3:0] CCT_CYC_5 = 4'h5;
    // User code limits per memory option
    localparam logic [15:0] CCT_LIMIT_LARGE = 16'h1DFF;
    localparam logic [15:0] CCT_LIMIT_MID = 16'h0FFF;
    localparam logic [15:0] CCT_LIMIT_SMALL = 16'h07FF;
    // Reset source register field positions
    localparam int CCT_FLASH_FAULT_BIT = 6;
    localparam int CCT_SW_FORCE_BIT = 4;
    localparam logic [7:0] CCT_RSRC_RESET = 8'h00;
    // Reset vector
    localparam logic [15:0] CCT_RESET_VECTOR = 16'h0000;
    // Delay from reset release to first fetch, in ns
    localparam int CCT_CLK_PERIOD_NS = 8;
    localparam int CCT_START_DELAY_NS = 5000;
    localparam int CCT_START_CYCLES =
        (CCT_START_DELAY_NS + CCT_CLK_PERIOD_NS - 1) / CCT_CLK_PERIOD_NS;
    localparam logic [9:0] CCT_START_CNT = 10'(CCT_START_CYCLES);
    // States of the timing sequencer
    typedef enum logic [1:0] {
        CCT_ST_HOLD = 2'b00,
        CCT_ST_IDLE = 2'b01,
        CCT_ST_BUSY = 2'b11
    } cct_state_t;
endpackage

/* File: test/cct_soft_model.sv */
`timescale 1ns/1ps
// Stands in for user software offering instructions to the core
module cct_soft_model (
    input wire logic i_ref_clk,
    input wire logic i_op_ready,
    output logic o_op_valid,
    output logic [7:0] o_opcode,
    output logic o_cond_taken,
    output logic o_bit_value,
    output logic [15:0] o_pc,
    output logic [15:0] o_target,
    output logic o_is_branch,
    output logic [15:0] o_mem_addr,
    output logic o_store_wr_en,
    output logic o_rsrc_wr,
    output logic [7:0] o_rsrc_wdata
);
    // Quiet state at time zero; the fetch address stays low in user space
    initial
    begin
        o_op_valid = 1'b0;
        o_opcode = 8'h00;
        o_cond_taken = 1'b0;
        o_bit_value = 1'b0;
        o_pc = 16'h0010;
        o_target = 16'h0100;
        o_is_branch = 1'b0;
        o_mem_addr = 16'h0040;
        o_store_wr_en = 1'b1;
        o_rsrc_wr = 1'b0;
        o_rsrc_wdata = 8'h00;
    end

    // Offer one instruction and hold it until the core is seen ready
    task offer(input logic [7:0] op, input logic tk, input logic [15:0] tgt,
               input logic br, input logic [15:0] addr);
        int n;
        @(negedge i_ref_clk);
        o_op_valid = 1'b1;
        o_opcode = op;
        o_cond_taken = tk;
        o_bit_value = tk;
        o_target = tgt;
        o_is_branch = br;
        o_mem_addr = addr;
        // Ready is settled at the falling edge; the next rising edge takes
        n = 0;
        while (i_op_ready !== 1'b1 && n < 800)
        begin
            @(negedge i_ref_clk);
            n++;
        end
        @(posedge i_ref_clk);
    endtask

    // Released fields show inverted data so stale values never look valid
    task release_req;
        o_op_valid = 1'b0;
        o_opcode = ~o_opcode;
        o_cond_taken = ~o_cond_taken;
        o_bit_value = ~o_bit_value;
        o_target = ~o_target;
        o_is_branch = 1'b0;
        o_mem_addr = ~o_mem_addr;
    endtask

    // One-cycle write of the force bit to the reset source register
    task sw_reset;
        @(negedge i_ref_clk);
        o_rsrc_wr = 1'b1;
        o_rsrc_wdata = 8'h10;
        @(negedge i_ref_clk);
        o_rsrc_wr = 1'b0;
        o_rsrc_wdata = 8'hEF;
    endtask
endmodule

/* File: test/test_core_cycle_timing_fault_reset.sv */
`timescale 1ns/1ps
module test_core_cycle_timing_fault_reset;
    import cct_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic op_valid, cond_taken, bit_value, is_branch, store_wr_en, rsrc_wr;
    logic [7:0] opcode, rsrc_wdata, o_reset_source_register;
    logic [15:0] pc, target, mem_addr, o_fetch_addr;
    logic o_op_ready, o_done, o_clear_bit, o_flash_sel, o_flash_wr;
    logic o_flash_rd, o_core_rst, o_pin_rst_drive;
    logic [1:0] o_len;
    logic [3:0] o_cycles;
    int fails = 0;
    int samples_checked = 0;
    logic [15:0] maddr = 16'h0040; // Data address for normal moves

    always #4 i_ref_clk = ~i_ref_clk;

    cct_soft_model sw (.i_ref_clk(i_ref_clk), .i_op_ready(o_op_ready),
        .o_op_valid(op_valid), .o_opcode(opcode), .o_cond_taken(cond_taken),
        .o_bit_value(bit_value), .o_pc(pc), .o_target(target),
        .o_is_branch(is_branch), .o_mem_addr(mem_addr),
        .o_store_wr_en(store_wr_en),
        .o_rsrc_wr(rsrc_wr), .o_rsrc_wdata(rsrc_wdata));

    // External reset pin held idle: pin reset is outside this bench
    cct_core_timing dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_pin_rst(1'b0), .i_op_valid(op_valid), .i_opcode(opcode),
        .i_cond_taken(cond_taken), .i_bit_value(bit_value), .i_pc(pc),
        .i_target(target), .i_is_branch(is_branch), .i_mem_addr(mem_addr),
        .i_program_store_write_enable(store_wr_en), .i_rsrc_wr(rsrc_wr),
        .i_rsrc_wdata(rsrc_wdata), .o_op_ready(o_op_ready), .o_done(o_done),
        .o_len(o_len), .o_cycles(o_cycles), .o_clear_bit(o_clear_bit),
        .o_flash_sel(o_flash_sel), .o_flash_wr(o_flash_wr),
        .o_flash_rd(o_flash_rd), .o_fetch_addr(o_fetch_addr),
        .o_core_rst(o_core_rst), .o_pin_rst_drive(o_pin_rst_drive),
        .o_reset_source_register(o_reset_source_register));

    // Compare one value and count it
    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task results;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Count settled cycles until the core accepts work again
    task wait_ready(output int n);
        n = 0;
        while (o_op_ready !== 1'b1 && n < 800)
        begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
    endtask

    // One instruction: edges from taking to done must equal its cycles
    task run(input logic [7:0] op, input logic tk, input logic [1:0] len,
             input logic [3:0] cyc);
        int n;
        logic [2:0] fl;
        sw.offer(op, tk, 16'h0100, tk, maddr);
        fl = 3'h0;
        for (n = 1; n <= 12; n++)
        begin
            @(negedge i_ref_clk);
            if (n == 1)
                sw.release_req();
            @(posedge i_ref_clk);
            #1;
            if (n == 1)
                fl = {o_flash_sel, o_flash_wr, o_flash_rd};
            if (o_done === 1'b1)
                break;
        end
        chk(16'(n), 16'(cyc));
        chk(16'(o_len), 16'(len));
        chk(16'(o_cycles), 16'(cyc));
        if (op[7:5] == 3'b111)
            chk(16'(fl), {13'h0, 1'b1, op[4], !op[4]});
        if (op == 8'h10)
            chk(16'(o_clear_bit), 16'(tk));
    endtask

    task t_reset;
        int n;
        chk(16'(o_core_rst), 16'h1);
        chk(o_fetch_addr, CCT_RESET_VECTOR);
        chk(16'(o_reset_source_register), 16'(CCT_RSRC_RESET));
        wait_ready(n);
        chk(16'(n >= CCT_START_CYCLES), 16'h1);
        $display("test reset done");
    endtask

    // Every timing group; each conditional branch is run with one outcome only
    task t_timing;
        run(8'h28, 0, 1, 1);
        run(8'h25, 0, 2, 2);
        run(8'h26, 0, 1, 2);
        run(8'h94, 0, 2, 2);
        run(8'h58, 0, 1, 1);
        run(8'h55, 0, 2, 2);
        run(8'h56, 0, 1, 2);
        run(8'h83, 0, 1, 3);
        run(8'hE0, 0, 1, 3);
        run(8'hF0, 0, 1, 3);
        run(8'hE2, 0, 1, 3);
        run(8'hF2, 0, 1, 3);
        run(8'hC0, 0, 2, 2);
        run(8'hD0, 0, 2, 2);
        run(8'hC8, 0, 1, 1);
        run(8'hC5, 0, 2, 2);
        run(8'hD6, 0, 1, 2);
        run(8'hC3, 0, 1, 1);
        run(8'hB3, 0, 1, 1);
        run(8'h82, 0, 2, 2);
        run(8'h40, 0, 2, 2);
        run(8'h50, 1, 2, 3);
        run(8'h20, 0, 3, 3);
        run(8'h10, 1, 3, 4);
        run(8'h11, 1, 2, 3);
        run(8'h12, 1, 3, 4);
        run(8'h80, 1, 2, 3);
        run(8'h22, 1, 1, 5);
        run(8'h32, 1, 1, 5);
        run(8'h73, 1, 1, 3);
        run(8'h60, 1, 2, 3);
        maddr = CCT_LIMIT_LARGE;
        run(8'hF0, 0, 1, 3);
        $display("test timing done");
    endtask

    task t_swreset;
        int n;
        sw.sw_reset();
        chk(16'(o_core_rst), 16'h1);
        chk(16'(o_pin_rst_drive), 16'h0);
        wait_ready(n);
        chk(16'(o_reset_source_register[CCT_SW_FORCE_BIT]), 16'h1);
        chk(16'(o_reset_source_register[CCT_FLASH_FAULT_BIT]), 16'h0);
        $display("test software reset done");
    endtask

    // Access past the user limit: no completion, internal reset, flag set
    task t_fault(input logic [7:0] op, input logic [15:0] addr,
                 input logic br, input logic [15:0] tgt);
        int n;
        logic seen;
        // A branch offered here is a taken one
        sw.offer(op, br, tgt, br, addr);
        seen = 1'b0;
        for (n = 1; n <= 3; n++)
        begin
            @(negedge i_ref_clk);
            if (n == 1)
                sw.release_req();
            if (o_core_rst === 1'b1)
                seen = 1'b1;
            chk(16'(o_done), 16'h0);
        end
        chk(16'(seen), 16'h1);
        chk(16'(o_pin_rst_drive), 16'h0);
        wait_ready(n);
        chk(16'(o_reset_source_register[CCT_FLASH_FAULT_BIT]), 16'h1);
        chk(o_fetch_addr, CCT_RESET_VECTOR);
        $display("test fault %h done", op);
    endtask

    // Watchdog well beyond the roughly 3300 cycles the tests need
    initial
    begin
        repeat (20000) @(posedge i_ref_clk);
        fails++;
        results();
    end

    initial
    begin
        repeat (4) @(negedge i_ref_clk);
        i_sys_rst = 1'b0;
        t_reset();
        t_timing();
        t_swreset();
        t_fault(8'hF0, CCT_LIMIT_LARGE + 16'h1, 1'b0, 16'h0100);
        t_fault(8'h83, CCT_LIMIT_LARGE + 16'h1, 1'b0, 16'h0100);
        t_fault(8'h02, 16'h0040, 1'b1, CCT_LIMIT_LARGE + 16'h1);
        results();
    end
endmodule
